// file: shared/tpm_pkg.sv
// constants and types for the timer channel
// Behaviour
// - two-bit source code picks clock: 00 undivided, 01 /8, 10 /32, 11 subclock/32
// - measurement counts up; each effective edge copies count to reload, clears count to zero, keeps counting
// - measurement runs while the start flag is 1, halts when it is 0
// - every effective edge requests an interrupt except the first after start
// - overflow in measurement requests an interrupt and sets the overflow flag
// - overflow flag clears only on a mode register write while start is 1
// - count register read in measurement returns the reload register
// - measured value is undefined until the second effective edge
// - count register writes in measurement change nothing
// - modulation counts down, as one 16-bit or 8-bit with 8-bit prescaler
// - modulator reloads at each rising output edge and keeps counting
// - triggers during modulation are ignored
// - 16-bit: high n count periods, period 2^16-1 periods
// - 8-bit: high n*(m+1), period 255*(m+1); n upper byte, m lower
// - modulation output runs while start is 1, stops when cleared
// - 8-bit request at output fall; width FF or 00 at count 01
// - 16-bit request at output fall; width FFFF or 0000 at count 0001
// - zero width holds output low and loads all ones as width
// - count register read in modulation is undefined
// - count write while stopped updates reload and counter together
// - count write while running updates reload only, used at next reload
package tpm_pkg;

   // register byte offsets
   localparam logic [7:0] ADDR_MODE   = 8'h00;
   localparam logic [7:0] ADDR_COUNT  = 8'h04;
   localparam logic [7:0] ADDR_START  = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;

   // channel_mode_register fields
   localparam int MODE_PWM   = 0;
   localparam int MODE_PWM8  = 1;
   localparam int MODE_WIDTH = 2;
   localparam int MODE_RISE  = 3;
   localparam int MODE_SRC   = 6;
   localparam logic [7:0] MODE_RST = 8'h00;

   // status fields
   localparam int STAT_OVF   = 0;
   localparam int STAT_VALID = 1;

   // count source codes
   localparam logic [1:0] SRC_F1   = 2'h0;
   localparam logic [1:0] SRC_F8   = 2'h1;
   localparam logic [1:0] SRC_F32  = 2'h2;
   localparam logic [1:0] SRC_SUBCLOCK_DIV32 = 2'h3;
   localparam logic [4:0] DIV8_END  = 5'h07;
   localparam logic [4:0] DIV32_END = 5'h1F;

   // counter figures
   localparam logic [15:0] CNT_MAX  = 16'hFFFF;
   localparam logic [15:0] PER16    = 16'hFFFE;
   localparam logic [7:0]  PER8     = 8'hFE;
   localparam logic [15:0] CNT_ONE  = 16'h0001;
   localparam logic [7:0]  BYTE_ONE = 8'h01;
   localparam logic [1:0]  EDGES_OK = 2'h2;

   // synchroniser lanes
   localparam int SYNC_W   = 2;
   localparam int LANE_PIN = 0;
   localparam int LANE_SUB = 1;

   // apb request and answer
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } tpm_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } tpm_apb_rsp_t;

   // channel_io_pin drive
   typedef struct packed {
      logic o;
      logic oe;
   } tpm_pin_drv_t;

   // core state
   typedef struct packed {
      logic [7:0]   mode;
      logic         start;
      logic         ovf;
      logic [15:0]  reload;
      logic [15:0]  cnt;
      logic [15:0]  width;
      logic         zero_w;
      logic [1:0]   edges;
      logic         pin_prev;
      logic         irq;
      tpm_pin_drv_t pin;
      tpm_apb_rsp_t rsp;
   } tpm_core_t;

endpackage

// file: verilog/tpm_sync.sv
// two-flop synchronisers for pin inputs
module tpm_sync (
   // clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // raw and synchronised levels
   input  wire logic [tpm_pkg::SYNC_W-1:0] d_in,
   output logic      [tpm_pkg::SYNC_W-1:0] d_out
);

   typedef struct packed {
      logic [tpm_pkg::SYNC_W-1:0] ff1;
      logic [tpm_pkg::SYNC_W-1:0] ff2;
   } tpm_sync_t;

   tpm_sync_t s_reg;
   tpm_sync_t s_next;

   // one lane per input; first flop feeds only the second
   genvar g;
   generate
      for (g = 0; g < tpm_pkg::SYNC_W; g = g + 1) begin : lane
         always_comb begin
            s_next.ff1[g] = d_in[g];
            s_next.ff2[g] = s_reg.ff1[g];
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign d_out = s_reg.ff2;

endmodule

// file: verilog/tpm_presc.sv
// count clock prescaler
module tpm_presc (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // source select and synchronised subclock
   input  wire logic [1:0] src_sel,
   input  wire logic       sub_lvl,
   // one-cycle count tick
   output logic            tick
);

   typedef struct packed {
      logic [4:0] div;
      logic [4:0] sdiv;
      logic       sprev;
      logic       tick;
   } tpm_presc_t;

   tpm_presc_t p_reg;
   tpm_presc_t p_next;

   // pick the divided tick by source code
   always_comb begin
      p_next       = p_reg;
      p_next.div   = p_reg.div + 5'h01;
      p_next.sprev = sub_lvl;
      if (sub_lvl && !p_reg.sprev) begin
         p_next.sdiv = p_reg.sdiv + 5'h01;
      end
      if (src_sel == tpm_pkg::SRC_F1) begin
         p_next.tick = 1'b1;
      end else if (src_sel == tpm_pkg::SRC_F8) begin
         p_next.tick = (p_reg.div[2:0] == tpm_pkg::DIV8_END[2:0]);
      end else if (src_sel == tpm_pkg::SRC_F32) begin
         p_next.tick = (p_reg.div == tpm_pkg::DIV32_END);
      end else begin
         p_next.tick = sub_lvl && !p_reg.sprev && (p_reg.sdiv == tpm_pkg::DIV32_END);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p_reg <= '0;
      end else begin
         p_reg <= p_next;
      end
   end

   assign tick = p_reg.tick;

endmodule

// file: verilog/tpm_timer.sv
// timer channel: pulse measurement and pulse width modulation
//
// Added by the designer: the APB slave port and the address map.
module tpm_timer (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // apb slave
   input  wire tpm_pkg::tpm_apb_req_t apb_req,
   output tpm_pkg::tpm_apb_rsp_t      apb_rsp,
   // channel_io_pin and subclock
   input  wire logic                  channel_io_pin_in,
   output tpm_pkg::tpm_pin_drv_t      channel_io_pin,
   input  wire logic                  subclock_in,
   // interrupt request pulse
   output logic                       irq_req
);

   tpm_pkg::tpm_core_t r_reg;
   tpm_pkg::tpm_core_t r_next;

   logic [tpm_pkg::SYNC_W-1:0] raw;
   logic [tpm_pkg::SYNC_W-1:0] syn;
   logic                       tick;
   logic                       pin_s;
   logic                       meas;
   logic                       pwm8;
   logic                       rise;
   logic                       fall;
   logic                       eff;
   logic                       xfer;
   logic                       wr;
   logic                       wr_mode;
   logic                       wr_cnt;
   logic                       wr_start;

   // pin and subclock cross in through two flops
   assign raw[tpm_pkg::LANE_PIN] = channel_io_pin_in;
   assign raw[tpm_pkg::LANE_SUB] = subclock_in;

   tpm_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d_in    (raw),
      .d_out   (syn)
   );

   tpm_presc u_presc (
      .pclk    (pclk),
      .presetn (presetn),
      .src_sel (r_reg.mode[tpm_pkg::MODE_SRC +: 2]),
      .sub_lvl (syn[tpm_pkg::LANE_SUB]),
      .tick    (tick)
   );

   assign pin_s = syn[tpm_pkg::LANE_PIN];

   // mode and edge decode
   assign meas = !r_reg.mode[tpm_pkg::MODE_PWM];
   assign pwm8 = r_reg.mode[tpm_pkg::MODE_PWM8];
   assign rise = pin_s && !r_reg.pin_prev;
   assign fall = !pin_s && r_reg.pin_prev;

   // period uses one polarity, width every edge
   always_comb begin
      if (r_reg.mode[tpm_pkg::MODE_WIDTH]) begin
         eff = rise || fall;
      end else if (r_reg.mode[tpm_pkg::MODE_RISE]) begin
         eff = rise;
      end else begin
         eff = fall;
      end
   end

   // a write lands on the edge that completes the access
   assign xfer     = apb_req.psel && apb_req.penable && r_reg.rsp.pready;
   assign wr       = xfer && apb_req.pwrite;
   assign wr_mode  = wr && (apb_req.paddr == tpm_pkg::ADDR_MODE);
   assign wr_cnt   = wr && (apb_req.paddr == tpm_pkg::ADDR_COUNT);
   assign wr_start = wr && (apb_req.paddr == tpm_pkg::ADDR_START);

   // width to load; zero becomes all ones with output held low
   function automatic logic [16:0] load_w(input logic [15:0] v, input logic b8);
      logic [16:0] res;
      res = {1'b0, v};
      if (b8 && v[15:8] == 8'h00) begin
         res = {1'b1, 8'hFF, v[7:0]};
      end else if (!b8 && v == 16'h0000) begin
         res = {1'b1, tpm_pkg::CNT_MAX};
      end
      return res;
   endfunction

   // output level for a given counter position
   function automatic logic pwm_lvl(input tpm_pkg::tpm_core_t s, input logic b8);
      logic lv;
      lv = 1'b0;
      if (s.zero_w) begin
         lv = 1'b0;
      end else if (b8) begin
         lv = ((tpm_pkg::PER8 - s.cnt[15:8]) < s.width[15:8]);
      end else begin
         lv = ((tpm_pkg::PER16 - s.cnt) < s.width);
      end
      return lv;
   endfunction

   // whole channel next state
   always_comb begin
      r_next          = r_reg;
      r_next.irq      = 1'b0;
      r_next.pin_prev = pin_s;

      // software side of the registers
      if (wr_mode) begin
         r_next.mode = apb_req.pwdata[7:0];
         if (r_reg.start) begin
            r_next.ovf = 1'b0;
         end
      end
      if (wr_start) begin
         r_next.start = apb_req.pwdata[0];
         if (apb_req.pwdata[0] && !r_reg.start) begin
            r_next.cnt   = '0;
            r_next.edges = '0;
         end
      end
      // measurement mode ignores count writes
      if (wr_cnt && !meas) begin
         r_next.reload = apb_req.pwdata[15:0];
         if (!r_reg.start) begin
            {r_next.zero_w, r_next.width} = load_w(apb_req.pwdata[15:0], pwm8);
            r_next.cnt = '0;
         end
      end

      // measurement: up count, capture on edges
      if (meas && r_reg.start) begin
         if (tick) begin
            r_next.cnt = r_reg.cnt + 16'h0001;
            if (r_reg.cnt == tpm_pkg::CNT_MAX) begin
               r_next.ovf = 1'b1;
               r_next.irq = 1'b1;
            end
         end
         if (eff) begin
            r_next.reload = r_reg.cnt;
            r_next.cnt    = '0;
            if (r_reg.edges != tpm_pkg::EDGES_OK) begin
               r_next.edges = r_reg.edges + 2'h1;
            end
            if (r_reg.edges != 2'h0) begin
               r_next.irq = 1'b1;
            end
         end
      end

      // modulation: down count, pin never read here
      if (!meas && r_reg.start && tick) begin
         if (pwm8) begin
            if (r_reg.cnt[7:0] == 8'h00) begin
               r_next.cnt[7:0] = r_reg.width[7:0];
               if (r_reg.cnt[15:8] == 8'h00) begin
                  r_next.cnt[15:8] = tpm_pkg::PER8;
                  {r_next.zero_w, r_next.width} = load_w(r_reg.reload, 1'b1);
                  r_next.cnt[7:0] = r_reg.reload[7:0];
               end else begin
                  r_next.cnt[15:8] = r_reg.cnt[15:8] - 8'h01;
                  if (r_reg.cnt[15:8] == 8'h02
                      && r_reg.width[15:8] == 8'hFF) begin
                     r_next.irq = 1'b1;
                  end
               end
            end else begin
               r_next.cnt[7:0] = r_reg.cnt[7:0] - 8'h01;
            end
         end else begin
            if (r_reg.cnt == 16'h0000) begin
               r_next.cnt = tpm_pkg::PER16;
               {r_next.zero_w, r_next.width} = load_w(r_reg.reload, 1'b0);
            end else begin
               r_next.cnt = r_reg.cnt - 16'h0001;
               if (r_reg.cnt == 16'h0002 && r_reg.width == tpm_pkg::CNT_MAX) begin
                  r_next.irq = 1'b1;
               end
            end
         end
      end

      // output level and its falling-edge request
      if (!meas && r_next.start) begin
         r_next.pin.o = pwm_lvl(r_next, pwm8);
      end else begin
         r_next.pin.o = 1'b0;
      end
      if (!meas && r_reg.pin.o && !r_next.pin.o && r_next.start) begin
         r_next.irq = 1'b1;
      end
      r_next.pin.oe = !meas;

      // apb answer: one wait state, data held in a flop
      r_next.rsp.pready  = 1'b0;
      r_next.rsp.pslverr = 1'b0;
      if (apb_req.psel && apb_req.penable && !r_reg.rsp.pready) begin
         r_next.rsp.pready = 1'b1;
         r_next.rsp.prdata = '0;
         if (apb_req.paddr == tpm_pkg::ADDR_MODE) begin
            r_next.rsp.prdata[7:0] = r_reg.mode;
         end else if (apb_req.paddr == tpm_pkg::ADDR_COUNT) begin
            // modulation reads show the live counter, not meaningful
            r_next.rsp.prdata[15:0] = meas ? r_reg.reload : r_reg.cnt;
         end else if (apb_req.paddr == tpm_pkg::ADDR_START) begin
            r_next.rsp.prdata[0] = r_reg.start;
         end else if (apb_req.paddr == tpm_pkg::ADDR_STATUS) begin
            r_next.rsp.prdata[tpm_pkg::STAT_OVF]   = r_reg.ovf;
            r_next.rsp.prdata[tpm_pkg::STAT_VALID] = (r_reg.edges == tpm_pkg::EDGES_OK);
         end else begin
            r_next.rsp.pslverr = 1'b1;
         end
      end
   end

   // single state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg      <= '0;
         r_reg.mode <= tpm_pkg::MODE_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   assign apb_rsp        = r_reg.rsp;
   assign channel_io_pin = r_reg.pin;
   assign irq_req        = r_reg.irq;

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_meas_run;
      meas && r_reg.start && !wr_mode && !wr_start;
   endsequence

   sequence s_pwm16_run;
      !meas && !pwm8 && r_reg.start && !wr_mode && !wr_start;
   endsequence

   sequence s_pwm8_run;
      !meas && pwm8 && r_reg.start && !wr_mode && !wr_start;
   endsequence

   a_ovf_set_flag: assert property (
      s_meas_run ##0 (tick && r_reg.cnt == tpm_pkg::CNT_MAX)
      |=> r_reg.ovf && irq_req)
      else $error("overflow did not set flag and request");

   a_ovf_only_clear: assert property (
      r_reg.ovf && !(wr_mode && r_reg.start) |=> r_reg.ovf)
      else $error("overflow flag cleared without mode write");

   a_meas_capture: assert property (
      s_meas_run ##0 eff |=> r_reg.reload == $past(r_reg.cnt) && r_reg.cnt == 16'h0000)
      else $error("edge did not capture the count");

   a_first_edge_quiet: assert property (
      s_meas_run ##0 (eff && r_reg.edges == 2'h0)
      ##0 !(tick && r_reg.cnt == tpm_pkg::CNT_MAX) |=> !irq_req)
      else $error("first edge raised a request");

   a_later_edge_irq: assert property (
      s_meas_run ##0 (eff && r_reg.edges != 2'h0) |=> irq_req)
      else $error("later edge raised no request");

   a_stopped_stable: assert property (
      meas && !r_reg.start && !wr_start |=> $stable(r_reg.cnt))
      else $error("counter moved while stopped");

   a_meas_no_write: assert property (
      meas && wr_cnt && !(r_reg.start && eff) |=> $stable(r_reg.reload))
      else $error("count write changed reload in measurement");

   a_count_read: assert property (
      meas && apb_req.psel && apb_req.penable && !r_reg.rsp.pready
      && apb_req.paddr == tpm_pkg::ADDR_COUNT
      |=> r_reg.rsp.pready && r_reg.rsp.prdata[15:0] == $past(r_reg.reload))
      else $error("count read did not return reload");

   a_zero_width_low: assert property (
      r_reg.zero_w |-> !r_reg.pin.o)
      else $error("zero width drove the output high");

   a_stop_low: assert property (
      !r_reg.start |-> !r_reg.pin.o)
      else $error("output high while stopped");

   a_pwm_reload: assert property (
      s_pwm16_run ##0 (tick && r_reg.cnt == 16'h0000 && !wr_cnt)
      |=> r_reg.cnt == tpm_pkg::PER16
      && r_reg.width == (($past(r_reg.reload) == 16'h0000)
                         ? tpm_pkg::CNT_MAX : $past(r_reg.reload)))
      else $error("modulator did not reload");

   a_pin_dir: assert property (
      ##1 r_reg.pin.oe == $past(!meas))
      else $error("pin direction does not follow mode");

   // measurement and start steps
   a_count_up: assert property (
      s_meas_run ##0 (tick && !eff)
      |=> r_reg.cnt == $past(r_reg.cnt) + 16'h0001)
      else $error("measurement counter did not step up");

   a_start_clears: assert property (
      wr_start && apb_req.pwdata[0] && !r_reg.start
      |=> r_reg.cnt == 16'h0000 && r_reg.edges == 2'h0)
      else $error("start did not clear counter and edges");

   // modulation steps
   a_pwm16_down: assert property (
      s_pwm16_run ##0 (tick && r_reg.cnt != 16'h0000)
      |=> r_reg.cnt == $past(r_reg.cnt) - 16'h0001)
      else $error("16-bit modulator did not step down");

   a_pwm8_reload: assert property (
      s_pwm8_run ##0 (tick && r_reg.cnt == 16'h0000 && !wr_cnt)
      |=> r_reg.cnt[15:8] == tpm_pkg::PER8)
      else $error("8-bit modulator did not reload");

   a_pwm8_full_irq: assert property (
      s_pwm8_run ##0 (tick && r_reg.cnt == 16'h0200 && r_reg.width[15:8] == 8'hFF)
      |=> irq_req && r_reg.cnt[15:8] == tpm_pkg::BYTE_ONE)
      else $error("full width gave no request at count one");

   a_fall_irq: assert property (
      (!meas && r_reg.pin.o) ##1 (!r_reg.pin.o && r_reg.start) |-> irq_req)
      else $error("output fall raised no request");

   // register bus answer
   a_ready_one: assert property (
      r_reg.rsp.pready |=> !r_reg.rsp.pready)
      else $error("ready stood longer than one cycle");

   a_unmapped_err: assert property (
      apb_req.psel && apb_req.penable && !r_reg.rsp.pready
      && apb_req.paddr != tpm_pkg::ADDR_MODE && apb_req.paddr != tpm_pkg::ADDR_COUNT
      && apb_req.paddr != tpm_pkg::ADDR_START && apb_req.paddr != tpm_pkg::ADDR_STATUS
      |=> r_reg.rsp.pslverr)
      else $error("unmapped address gave no error");

endmodule

// file: testbench/tpm_pin_model.sv
// far-side model: pulse source on the pin, and a load that times the output
module tpm_pin_model (
   // clock
   input  wire logic                  pclk,
   // pin drive from the channel, source control
   input  wire tpm_pkg::tpm_pin_drv_t drv,
   input  wire logic                  run,
   input  wire logic [31:0]           half,
   // level on the pin and measured output timing
   output logic                       pin_lvl,
   output int                         last_hi,
   output int                         last_per
);
   timeunit 1ns;
   timeprecision 1ps;
   logic src;
   logic o_prev;
   int   cnt;
   int   hi;
   int   per;

   initial begin
      {src, o_prev, cnt, hi, per, last_hi, last_per} = '0;
   end

   // square wave source; a real source holds its level when halted
   always @(posedge pclk) begin
      if (run && !drv.oe) begin
         cnt <= (cnt + 1 >= half) ? 0 : cnt + 1;
         if (cnt + 1 >= half) src <= ~src;
      end
   end

   // high time and rise-to-rise period of the driven output, in pclk cycles
   always @(posedge pclk) begin
      o_prev <= drv.oe & drv.o;
      per    <= per + 1;
      if (drv.oe && drv.o) hi <= hi + 1;
      else if (hi != 0) begin
         last_hi <= hi;
         hi      <= 0;
      end
      if (drv.oe && drv.o && !o_prev) begin
         last_per <= per;
         per      <= 1;
      end
   end

   // the channel wins the pin while its output enable is high
   assign pin_lvl = drv.oe ? drv.o : src;
endmodule

// file: testbench/testbench.sv
// self-checking bench for the timer channel
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  pclk;
   logic                  presetn;
   tpm_pkg::tpm_apb_req_t req;
   tpm_pkg::tpm_apb_rsp_t rsp;
   tpm_pkg::tpm_pin_drv_t drv;
   logic                  pin_lvl;
   logic                  sub_clk;
   logic                  irq;
   logic                  run;
   logic                  o_prev;
   logic                  rerr;
   logic [31:0]           rdat;
   int                    half;
   int                    last_hi;
   int                    last_per;
   int                    err_count;
   int                    checked;
   int                    irq_n;
   int                    fall_n;

   tpm_timer uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .channel_io_pin_in(pin_lvl), .channel_io_pin(drv), .subclock_in(sub_clk),
      .irq_req(irq));
   tpm_pin_model far (.pclk(pclk), .drv(drv), .run(run), .half(half),
      .pin_lvl(pin_lvl), .last_hi(last_hi), .last_per(last_per));

   // 250 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // subclock toggles every cycle; counters only grow, scenarios take snapshots
   always @(posedge pclk) begin
      sub_clk <= ~sub_clk;
      o_prev  <= drv.o;
      if (irq === 1'b1) irq_n <= irq_n + 1;
      if (o_prev === 1'b1 && drv.o === 1'b0) fall_n <= fall_n + 1;
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s: got %h want %h", $time, m, seen, exp);
      end
   endtask

   task give_verdict;
      $display("mismatches %0d, comparisons %0d", err_count, checked);
      if (err_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task waitc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // one apb transfer; request held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      @(posedge pclk);
      while (rsp.pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 50) err_count++;
      rdat = rsp.prdata;
      rerr = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task wait_fall;
      int n;
      int b;
      n = 0;
      b = fall_n;
      while (fall_n == b && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 3000) err_count++;
   endtask

   task t_reset;
      apb(1'b0, tpm_pkg::ADDR_MODE, '0);
      chk(rdat, '0, "mode after reset");
      apb(1'b0, tpm_pkg::ADDR_STATUS, '0);
      chk(rdat, '0, "status after reset");
      apb(1'b0, 8'h10, '0);
      chk({rerr, rdat[30:0]}, 32'h80000000, "unmapped read");
      chk(drv.oe, '0, "pin is input");
   endtask

   // 16-bit modulation high time for every count source
   task t_pwm16;
      int dv[4];
      int b;
      dv = '{1, 8, 32, 64};
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, tpm_pkg::ADDR_START, '0);
         apb(1'b1, tpm_pkg::ADDR_MODE, {24'h0, i[1:0], 6'h01});
         apb(1'b1, tpm_pkg::ADDR_COUNT, 32'h3);
         chk(drv.oe, 1'b1, "pin driven");
         b = irq_n;
         apb(1'b1, tpm_pkg::ADDR_START, 32'h1);
         wait_fall;
         waitc(2);
         chk(last_hi, 3 * dv[i], "16-bit high time");
         chk(irq_n - b, 1, "request at fall");
      end
      apb(1'b1, tpm_pkg::ADDR_START, '0);
      waitc(2);
      chk(drv.o, '0, "stopped output low");
   endtask

   // 8-bit modulation, live reload and zero width
   task t_pwm8;
      int b;
      int f;
      apb(1'b1, tpm_pkg::ADDR_MODE, 32'h03);
      apb(1'b1, tpm_pkg::ADDR_COUNT, 32'h1001);
      apb(1'b1, tpm_pkg::ADDR_START, 32'h1);
      wait_fall;
      wait_fall;
      waitc(5);
      chk(last_hi, 32, "8-bit high time");
      chk(last_per, 510, "8-bit period");
      b = irq_n;
      f = fall_n;
      waitc(1020);
      chk(irq_n - b, 2, "request per fall");
      chk(fall_n - f, 2, "free running");
      apb(1'b1, tpm_pkg::ADDR_COUNT, 32'h2001);
      chk(last_hi, 32, "no change before reload");
      wait_fall;
      wait_fall;
      waitc(2);
      chk(last_hi, 64, "new width after reload");
      apb(1'b1, tpm_pkg::ADDR_COUNT, 32'h0001);
      waitc(600);
      b = irq_n;
      f = fall_n;
      waitc(510);
      chk(fall_n - f, 0, "zero width stays low");
      chk(irq_n - b, 1, "zero width request");
      chk(drv.o, '0, "zero width level");
      apb(1'b1, tpm_pkg::ADDR_START, '0);
   endtask

   // measurement of period or width; exp is the captured count, one less than the interval in ticks
   task t_meas(input logic [7:0] md, input int h, input int exp);
      int b;
      int n;
      apb(1'b1, tpm_pkg::ADDR_MODE, {24'h0, md});
      half <= h;
      run  <= 1'b1;
      waitc(2);
      chk(drv.oe, '0, "pin is input");
      b = irq_n;
      apb(1'b1, tpm_pkg::ADDR_START, 32'h1);
      n = 0;
      rdat = '0;
      while (rdat[tpm_pkg::STAT_VALID] !== 1'b1 && n < 200) begin
         apb(1'b0, tpm_pkg::ADDR_STATUS, '0);
         n++;
      end
      chk(rdat[tpm_pkg::STAT_VALID], 1'b1, "valid after two edges");
      chk(irq_n - b, 1, "first edge quiet");
      waitc(4 * h);
      apb(1'b1, tpm_pkg::ADDR_COUNT, 32'h1234);
      apb(1'b0, tpm_pkg::ADDR_COUNT, '0);
      chk(rdat, exp, "measured interval");
      apb(1'b1, tpm_pkg::ADDR_START, '0);
      run <= 1'b0;
   endtask

   // overflow with no edges, then the flag clearing condition
   task t_ovf;
      int b;
      int n;
      apb(1'b1, tpm_pkg::ADDR_MODE, '0);
      b = irq_n;
      apb(1'b1, tpm_pkg::ADDR_START, 32'h1);
      n = 0;
      while (irq_n == b && n < 70000) begin
         @(posedge pclk);
         n++;
      end
      chk(irq_n - b, 1, "overflow request");
      apb(1'b0, tpm_pkg::ADDR_STATUS, '0);
      chk(rdat[tpm_pkg::STAT_OVF], 1'b1, "overflow flag");
      apb(1'b1, tpm_pkg::ADDR_START, '0);
      apb(1'b1, tpm_pkg::ADDR_MODE, '0);
      apb(1'b0, tpm_pkg::ADDR_STATUS, '0);
      chk(rdat[tpm_pkg::STAT_OVF], 1'b1, "kept while stopped");
      apb(1'b1, tpm_pkg::ADDR_START, 32'h1);
      apb(1'b1, tpm_pkg::ADDR_MODE, '0);
      apb(1'b0, tpm_pkg::ADDR_STATUS, '0);
      chk(rdat[tpm_pkg::STAT_OVF], '0, "cleared by mode write");
   endtask

   // main sequence: reset for 20 cycles, then the scenarios
   initial begin
      presetn = 1'b0;
      req     = '0;
      sub_clk = 1'b0;
      {run, o_prev, rerr, rdat} = '0;
      {half, err_count, checked, irq_n, fall_n} = '0;
      waitc(20);
      presetn <= 1'b1;
      t_reset;
      t_pwm16;
      t_pwm8;
      t_meas(8'h08, 50, 99);
      t_meas(8'h04, 30, 29);
      t_meas(8'h00, 40, 79);
      t_ovf;
      give_verdict;
   end

   // watchdog: about 100k cycles, well past the 71k the scenarios need
   initial begin
      #400000;
      err_count++;
      give_verdict;
   end
endmodule
